// ### fsv_defs.vh
`ifndef FSV_DEFS_VH
`define FSV_DEFS_VH
// Clock rate in MHz
`define FSV_CLK_MHZ 25
// Startup times in microseconds
`define FSV_FUSE_LOAD_US 600
`define FSV_SELFTEST_US 700
// Overvoltage debounce times in microseconds
`define FSV_DBNC0_US 10
`define FSV_DBNC1_US 100
`define FSV_DBNC2_US 1000
// Clock cycles in one second
`define FSV_SEC_CYC 25000000
// Decay periods in minutes, one per selector code
`define FSV_OK_MIN0 1
`define FSV_OK_MIN1 5
`define FSV_OK_MIN2 10
`define FSV_OK_MIN3 15
`define FSV_OK_MIN4 20
`define FSV_OK_MIN5 30
`define FSV_OK_MIN6 45
`define FSV_OK_MIN7 60
`define FSV_SEC_PER_MIN 60
// Register indices
`define FSV_REG_FLAGS 4'h0
`define FSV_REG_COUNT 4'h1
`define FSV_REG_OVCTL 4'h2
`define FSV_REG_PWRCTL 4'h3
`define FSV_REG_STATE 4'h4
// Field positions
`define FSV_OV_EN_BIT 0
`define FSV_OV_SDWN_BIT 1
`define FSV_OV_DBNC_LSB 2
`define FSV_LPM_BIT 0
// Reset values
`define FSV_LPM_RST 1'b0
`define FSV_FLAGS_RST 4'h0
`endif

// ### fsv_failsafe_supervisor.v
`timescale 1ns/1ps
`include "fsv_defs.vh"
// Summary of operation
// - Failure flags persist while supply stays valid; a software write 1 or a new supply cycle clears.
// - Software reads flags when on; write 1 clears, only after successful power up.
// - Entering fail-safe transition compares 4-bit counter to limit, then increments unless equal.
// - Counter equal to limit locks the device down, safety-grade variant only.
// - Bypass fuse 1 always goes to off state; 0 allows lock-down on match.
// - Limit comes from 4-bit fuse; limit zero locks on first failure.
// - Lock-down is left only by a fresh supply cycle.
// - Decay period from 3-bit fuse: 1,5,10,15,20,30,45,60 minutes.
// - While on, each elapsed period decrements counter by one, stopping at zero.
// - Software may clear the counter while on; the device accepts it.
// - Fuses load into mirrors only after supply crossing; unpowered below it.
// - Debounced overvoltage: interrupt if shutdown bit 0, power down if 1.
// - Monitor enable bit gates monitor; enable and shutdown bits default from fuses.
// - Overvoltage in power up: fuse 0 continues with interrupt, 1 aborts to off.
// - Debounce select: 00=10us, 01=100us, 10=1000us, 11 reserved; fuse default.
// - With pin high, first sequence slot within 1.5 ms of supply crossing.
// - Low-power-off bit resets to 0; pin low keeps minimum-current off state.
// - Fuse load completes and is signalled within 600 us of supply crossing.
// - From minimum-current off, first slot within 800 us of pin rising.
// - Four cause flags: power up, watchdog, regulator, thermal; set on that shutdown.
// - Fault turn-off finishes power down, then fail-safe transition; others go off.

module fsv_failsafe_supervisor #(
  parameter [14:0] FUSE_CYC  = `FSV_FUSE_LOAD_US * `FSV_CLK_MHZ,
  parameter [14:0] TEST_CYC  = `FSV_SELFTEST_US * `FSV_CLK_MHZ,
  parameter [14:0] DBNC0_CYC = `FSV_DBNC0_US * `FSV_CLK_MHZ,
  parameter [14:0] DBNC1_CYC = `FSV_DBNC1_US * `FSV_CLK_MHZ,
  parameter [14:0] DBNC2_CYC = `FSV_DBNC2_US * `FSV_CLK_MHZ,
  parameter [24:0] SEC_CYC   = `FSV_SEC_CYC
) (
  // Clock and supply-valid reset
  input  wire        clk,
  input  wire        resetn,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Fuse contents
  input  wire [3:0]  fuse_failsafe_limit,
  input  wire        fuse_lockdown_bypass,
  input  wire [2:0]  fuse_decay_period_sel,
  input  wire        fuse_overvoltage_monitor_enable,
  input  wire        fuse_overvoltage_shutdown_sel,
  input  wire [1:0]  fuse_overvoltage_debounce_sel,
  input  wire        fuse_safety_grade,
  // Pins and comparators
  input  wire        power_on_request_pin,
  input  wire        input_overvoltage,
  // Sequencer and fault sources
  input  wire [3:0]  fault_cause,
  input  wire        off_request,
  input  wire        powerup_done,
  input  wire        powerdown_done,
  // Status and requests
  output reg         fuse_load_done,
  output reg         seq_start,
  output reg         powerdown_req,
  output reg         system_on,
  output reg         minimum_current_off_state,
  output reg         failsafe_locked,
  output reg         overvoltage_irq
);

  // One-hot states
  localparam [7:0] ST_LOAD  = 8'h01;
  localparam [7:0] ST_OFF   = 8'h02;
  localparam [7:0] ST_TEST  = 8'h04;
  localparam [7:0] ST_PWRUP = 8'h08;
  localparam [7:0] ST_ON    = 8'h10;
  localparam [7:0] ST_PWRDN = 8'h20;
  localparam [7:0] ST_FSTR  = 8'h40;
  localparam [7:0] ST_LOCK  = 8'h80;

  // Terminal counts
  localparam [14:0] FUSE_END = FUSE_CYC - 15'h1;
  localparam [14:0] TEST_END = TEST_CYC - 15'h1;
  localparam [24:0] SEC_END  = SEC_CYC - 25'h1;

  reg  [7:0]  state;
  reg  [14:0] tmr;
  reg         fault_pend;
  reg  [3:0]  fail_flags;
  reg  [3:0]  fs_count;
  // Mirrors of fuse data
  reg  [3:0]  lim_m;
  reg         byp_m;
  reg  [2:0]  per_m;
  reg         safe_m;
  reg         fsdwn_m;
  // Software-visible controls
  reg         ov_en;
  reg         ov_sdwn;
  reg  [1:0]  ov_dbnc;
  reg         lpm_off;
  // Overvoltage debounce
  reg  [14:0] ov_cnt;
  reg         ov_hit;
  reg         ov_evt;
  // Decay timer
  reg  [24:0] pre_cnt;
  reg  [11:0] sec_cnt;
  reg         decay_tick;

  wire load_end = (state == ST_LOAD) && (tmr == FUSE_END);
  wire wr_flags = reg_wr && (reg_addr == `FSV_REG_FLAGS);
  wire wr_count = reg_wr && (reg_addr == `FSV_REG_COUNT);
  wire wr_ovctl = reg_wr && (reg_addr == `FSV_REG_OVCTL);
  wire wr_pwr   = reg_wr && (reg_addr == `FSV_REG_PWRCTL);
  wire sw_clr   = wr_count && (state == ST_ON);
  wire fault_in = |fault_cause;
  wire at_limit = (fs_count == lim_m);
  wire lock_ok  = at_limit && safe_m && !byp_m;
  wire ov_block = ov_hit && ov_sdwn;

  // Decay period in seconds per selector code
  function [11:0] period_sec;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: period_sec = `FSV_OK_MIN0 * `FSV_SEC_PER_MIN;
        3'h1: period_sec = `FSV_OK_MIN1 * `FSV_SEC_PER_MIN;
        3'h2: period_sec = `FSV_OK_MIN2 * `FSV_SEC_PER_MIN;
        3'h3: period_sec = `FSV_OK_MIN3 * `FSV_SEC_PER_MIN;
        3'h4: period_sec = `FSV_OK_MIN4 * `FSV_SEC_PER_MIN;
        3'h5: period_sec = `FSV_OK_MIN5 * `FSV_SEC_PER_MIN;
        3'h6: period_sec = `FSV_OK_MIN6 * `FSV_SEC_PER_MIN;
        default: period_sec = `FSV_OK_MIN7 * `FSV_SEC_PER_MIN;
      endcase
    end
  endfunction

  // Debounce length; reserved code falls back to the longest
  function [14:0] dbnc_len;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: dbnc_len = DBNC0_CYC;
        2'h1: dbnc_len = DBNC1_CYC;
        default: dbnc_len = DBNC2_CYC;
      endcase
    end
  endfunction

  wire [11:0] per_end = period_sec(per_m) - 12'h1;
  wire [14:0] dbn_end = dbnc_len(ov_dbnc) - 15'h1;

  // Fuse mirrors, captured once at the end of fuse load
  always @(posedge clk) begin
    if (!resetn) begin
      lim_m   <= 4'h0;
      byp_m   <= 1'b0;
      per_m   <= 3'h0;
      safe_m  <= 1'b0;
      fsdwn_m <= 1'b0;
    end else if (load_end) begin
      lim_m   <= fuse_failsafe_limit;
      byp_m   <= fuse_lockdown_bypass;
      per_m   <= fuse_decay_period_sel;
      safe_m  <= fuse_safety_grade;
      fsdwn_m <= fuse_overvoltage_shutdown_sel;
    end
  end

  // Overvoltage controls: fuse defaults, then software; power control: reset value, then software
  always @(posedge clk) begin
    if (!resetn) begin
      ov_en   <= 1'b0;
      ov_sdwn <= 1'b0;
      ov_dbnc <= 2'h0;
      lpm_off <= `FSV_LPM_RST;
    end else if (load_end) begin
      ov_en   <= fuse_overvoltage_monitor_enable;
      ov_sdwn <= fuse_overvoltage_shutdown_sel;
      ov_dbnc <= fuse_overvoltage_debounce_sel;
    end else begin
      if (wr_ovctl) begin
        ov_en   <= reg_wdata[`FSV_OV_EN_BIT];
        ov_sdwn <= reg_wdata[`FSV_OV_SDWN_BIT];
        ov_dbnc <= reg_wdata[`FSV_OV_DBNC_LSB +: 2];
      end
      // Only meaningful while running
      if (wr_pwr && state == ST_ON)
        lpm_off <= reg_wdata[`FSV_LPM_BIT];
    end
  end

  // Overvoltage debounce; one event per excursion
  always @(posedge clk) begin
    if (!resetn) begin
      ov_cnt <= 15'h0;
      ov_hit <= 1'b0;
      ov_evt <= 1'b0;
    end else begin
      ov_evt <= 1'b0;
      if (!ov_en || !input_overvoltage || state == ST_LOAD) begin
        ov_cnt <= 15'h0;
        ov_hit <= 1'b0;
      end else if (!ov_hit) begin
        if (ov_cnt >= dbn_end) begin
          ov_hit <= 1'b1;
          ov_evt <= 1'b1;
        end else begin
          ov_cnt <= ov_cnt + 15'h1;
        end
      end
    end
  end

  // Decay timer: seconds prescaler, then period in seconds
  always @(posedge clk) begin
    if (!resetn) begin
      pre_cnt    <= 25'h0;
      sec_cnt    <= 12'h0;
      decay_tick <= 1'b0;
    end else begin
      decay_tick <= 1'b0;
      if (state != ST_ON || sw_clr) begin
        pre_cnt <= 25'h0;
        sec_cnt <= 12'h0;
      end else if (pre_cnt == SEC_END) begin
        pre_cnt <= 25'h0;
        if (sec_cnt >= per_end) begin
          sec_cnt    <= 12'h0;
          decay_tick <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + 12'h1;
        end
      end else begin
        pre_cnt <= pre_cnt + 25'h1;
      end
    end
  end

  // Fail-safe event counter
  always @(posedge clk) begin
    if (!resetn) begin
      fs_count <= 4'h0;
    end else if (state == ST_FSTR) begin
      // Compare happens in the state logic on the old value
      if (!at_limit)
        fs_count <= fs_count + 4'h1;
    end else if (sw_clr) begin
      fs_count <= 4'h0;
    end else if (decay_tick && fs_count != 4'h0) begin
      fs_count <= fs_count - 4'h1;
    end
  end

  // Failure-cause flags; a new cause beats a same-cycle clear
  always @(posedge clk) begin
    if (!resetn) begin
      fail_flags <= `FSV_FLAGS_RST;
    end else begin
      fail_flags <= (fail_flags
        & ~({4{wr_flags && state == ST_ON}} & reg_wdata[3:0]))
        | ({4{state == ST_PWRUP || state == ST_ON}}
        & fault_cause);
    end
  end

  // Main sequence
  always @(posedge clk) begin
    if (!resetn) begin
      state      <= ST_LOAD;
      tmr        <= 15'h0;
      fault_pend <= 1'b0;
    end else begin
      case (state)
        ST_LOAD: begin
          if (load_end) begin
            state <= ST_OFF;
            tmr   <= 15'h0;
          end else begin
            tmr <= tmr + 15'h1;
          end
        end
        ST_OFF: begin
          // Pin low leaves the device parked here
          if (power_on_request_pin && !ov_block) begin
            tmr <= 15'h0;
            if (lpm_off)
              state <= ST_PWRUP;
            else
              state <= ST_TEST;
          end
        end
        ST_TEST: begin
          if (tmr == TEST_END) begin
            state <= ST_PWRUP;
            tmr   <= 15'h0;
          end else begin
            tmr <= tmr + 15'h1;
          end
        end
        ST_PWRUP: begin
          if (fault_in) begin
            fault_pend <= 1'b1;
            state      <= ST_PWRDN;
          end else if (ov_evt && fsdwn_m) begin
            fault_pend <= 1'b0;
            state      <= ST_PWRDN;
          end else if (powerup_done) begin
            state <= ST_ON;
          end
        end
        ST_ON: begin
          if (fault_in) begin
            fault_pend <= 1'b1;
            state      <= ST_PWRDN;
          end else if (off_request || (ov_evt && ov_sdwn)) begin
            fault_pend <= 1'b0;
            state      <= ST_PWRDN;
          end
        end
        ST_PWRDN: begin
          if (powerdown_done) begin
            if (fault_pend)
              state <= ST_FSTR;
            else
              state <= ST_OFF;
          end
        end
        ST_FSTR: begin
          fault_pend <= 1'b0;
          if (lock_ok)
            state <= ST_LOCK;
          else
            state <= ST_OFF;
        end
        ST_LOCK: begin
          // Only the supply reset leaves this state
          state <= ST_LOCK;
        end
        default: begin
          state <= ST_LOAD;
          tmr   <= 15'h0;
        end
      endcase
    end
  end

  // Registered status outputs, decoded from the next state
  always @(posedge clk) begin
    if (!resetn) begin
      fuse_load_done            <= 1'b0;
      seq_start                 <= 1'b0;
      powerdown_req             <= 1'b0;
      system_on                 <= 1'b0;
      minimum_current_off_state <= 1'b0;
      failsafe_locked           <= 1'b0;
      overvoltage_irq           <= 1'b0;
    end else begin
      if (load_end)
        fuse_load_done <= 1'b1;
      // Pulse as the first slot begins
      seq_start <= (state == ST_OFF && power_on_request_pin &&
                    !ov_block && lpm_off) ||
                   (state == ST_TEST && tmr == TEST_END);
      powerdown_req <= (state == ST_PWRDN && !powerdown_done) ||
                       ((state == ST_PWRUP || state == ST_ON) &&
                        (fault_in || off_request || ov_evt &&
                         (state == ST_ON ? ov_sdwn : fsdwn_m)));
      system_on <= (state == ST_ON && !fault_in && !off_request &&
                    !(ov_evt && ov_sdwn)) ||
                   (state == ST_PWRUP && powerup_done && !fault_in &&
                    !(ov_evt && fsdwn_m));
      minimum_current_off_state <= (state == ST_OFF || load_end ||
        (state == ST_PWRDN && powerdown_done && !fault_pend) ||
        (state == ST_FSTR && !lock_ok)) && !lpm_off;
      failsafe_locked <= (state == ST_LOCK) ||
                         (state == ST_FSTR && lock_ok);
      // Interrupt only where no shutdown is taken
      overvoltage_irq <= ov_evt &&
        ((state == ST_ON && !ov_sdwn) ||
         (state == ST_PWRUP && !fsdwn_m));
    end
  end

  // Register reads: data only in the cycle after the strobe
  always @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `FSV_REG_FLAGS:  reg_rdata <= {4'h0, fail_flags};
        `FSV_REG_COUNT:  reg_rdata <= {lim_m, fs_count};
        `FSV_REG_OVCTL:  reg_rdata <= {4'h0, ov_dbnc, ov_sdwn, ov_en};
        `FSV_REG_PWRCTL: reg_rdata <= {7'h0, lpm_off};
        `FSV_REG_STATE:  reg_rdata <= state;
        default:         reg_rdata <= 8'h0;
      endcase
    end else begin
      reg_rdata <= 8'h0;
    end
  end

endmodule // fsv_failsafe_supervisor

// ### fsv_failsafe_props.sv
`timescale 1ns/1ps
module fsv_failsafe_props #(
  parameter [14:0] FUSE_CYC = 15'd20
) (
  // Clock and supply-valid reset
  input wire       clk,
  input wire       resetn,
  // Register port
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Comparators and sequencer
  input wire [3:0] fault_cause,
  input wire       input_overvoltage,
  input wire       powerdown_done,
  // Status
  input wire       fuse_load_done,
  input wire       seq_start,
  input wire       powerdown_req,
  input wire       system_on,
  input wire       minimum_current_off_state,
  input wire       failsafe_locked,
  input wire       overvoltage_irq
);
  // Cycles since supply became valid; saturates so it never wraps
  reg [15:0] up;
  always @(posedge clk) begin
    if (!resetn) up <= 16'h0000;
    else if (up != 16'hffff) up <= up + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_load_time: assert property ($rose(fuse_load_done) |->
    up + 16'h0001 >= FUSE_CYC && up <= FUSE_CYC + 1 && up <= 16'd15000)
    else $error("fuse load done at wrong time");
  a_load_hold: assert property (fuse_load_done |=> fuse_load_done)
    else $error("fuse load done dropped");
  a_lock_hold: assert property (failsafe_locked |=> failsafe_locked)
    else $error("lock-down released without supply cycle");
  a_lock_quiet: assert property (failsafe_locked |-> !system_on && !seq_start)
    else $error("activity while locked");
  a_start_pulse: assert property (seq_start |=> !seq_start)
    else $error("sequence start longer than one cycle");
  a_irq_cause: assert property (overvoltage_irq |->
    $past(input_overvoltage, 2) ##1 !overvoltage_irq)
    else $error("overvoltage interrupt without cause");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_fault_down: assert property (system_on && fault_cause != 4'h0
    |=> powerdown_req)
    else $error("fault did not start power down");
  a_down_end: assert property (powerdown_req && powerdown_done
    |-> ##[1:2] !powerdown_req)
    else $error("power down request not withdrawn");
  a_on_off_excl: assert property (!(system_on && minimum_current_off_state))
    else $error("on and off at once");
endmodule // fsv_failsafe_props

bind fsv_failsafe_supervisor fsv_failsafe_props #(.FUSE_CYC(FUSE_CYC))
  fsv_failsafe_props_inst (.clk(clk), .resetn(resetn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fault_cause(fault_cause),
  .input_overvoltage(input_overvoltage), .powerdown_done(powerdown_done),
  .fuse_load_done(fuse_load_done), .seq_start(seq_start),
  .powerdown_req(powerdown_req), .system_on(system_on),
  .minimum_current_off_state(minimum_current_off_state),
  .failsafe_locked(failsafe_locked), .overvoltage_irq(overvoltage_irq));

// ### fsv_seq_model.sv
`timescale 1ns/1ps
module fsv_seq_model (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Requests from the supervisor
  input wire       seq_start,
  input wire       powerdown_req,
  // Answer delay in cycles
  input wire [7:0] lag,
  // Completion pulses
  output reg       powerup_done,
  output reg       powerdown_done
);
  reg [7:0] up_cnt;
  reg [7:0] dn_cnt;
  reg       up_busy;
  reg       dn_busy;
  reg       req_q;
  // Slot runner; power down starts on the request edge only, since the
  // request stays up one cycle past our done pulse
  always @(posedge clk) begin
    if (!resetn) begin
      {powerup_done, powerdown_done, up_busy, dn_busy, req_q} <= 5'h00;
    end else begin
      powerup_done <= 1'b0;
      powerdown_done <= 1'b0;
      req_q <= powerdown_req;
      if (seq_start) begin
        up_busy <= 1'b1;
        up_cnt <= lag;
      end else if (up_busy && up_cnt == 8'h00) begin
        powerup_done <= 1'b1;
        up_busy <= 1'b0;
      end else if (up_busy) up_cnt <= up_cnt - 8'h01;
      if (powerdown_req && !req_q) begin
        dn_busy <= 1'b1;
        dn_cnt <= lag;
        up_busy <= 1'b0;
      end else if (dn_busy && dn_cnt == 8'h00) begin
        powerdown_done <= 1'b1;
        dn_busy <= 1'b0;
      end else if (dn_busy) dn_cnt <= dn_cnt - 8'h01;
    end
  end
endmodule // fsv_seq_model

// ### fsv_failsafe_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "fsv_defs.vh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, got, exp); end end
module fsv_failsafe_supervisor_tb_top;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [3:0] lim = 4'hf;
  reg        byp = 1'b1;
  reg        saf = 1'b1;
  reg        pin = 1'b0;
  reg        ov = 1'b0;
  reg  [3:0] fault_cause = 4'h0;
  reg        off_request = 1'b0;
  reg  [7:0] lag = 8'h03;
  wire [7:0] reg_rdata;
  wire       pu_done, pd_done, fld, seq_start, pd_req, sys_on, mc_off;
  wire       locked, irq;
  integer    errors = 0, n_checks = 0, cyc = 0, n, k;
  reg  [7:0] d;
  reg  [3:0] cfg [0:3];
  // Fuse levels that the supervisor copies at the end of fuse load
  reg  [2:0] f_per = 3'h0;
  reg        f_ov_en = 1'b1;
  reg        f_ov_sdwn = 1'b0;
  reg  [1:0] f_ov_dbnc = 2'h1;
  always #20 clk = ~clk;
  fsv_failsafe_supervisor #(.FUSE_CYC(15'd20), .TEST_CYC(15'd20),
    .DBNC1_CYC(15'd5), .DBNC2_CYC(15'd8),
    .SEC_CYC(25'd4)) fsv_failsafe_supervisor_inst (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fuse_failsafe_limit(lim), .fuse_lockdown_bypass(byp),
    .fuse_decay_period_sel(f_per), .fuse_overvoltage_monitor_enable(f_ov_en),
    .fuse_overvoltage_shutdown_sel(f_ov_sdwn),
    .fuse_overvoltage_debounce_sel(f_ov_dbnc), .fuse_safety_grade(saf),
    .power_on_request_pin(pin), .input_overvoltage(ov),
    .fault_cause(fault_cause), .off_request(off_request),
    .powerup_done(pu_done), .powerdown_done(pd_done), .fuse_load_done(fld),
    .seq_start(seq_start), .powerdown_req(pd_req), .system_on(sys_on),
    .minimum_current_off_state(mc_off), .failsafe_locked(locked),
    .overvoltage_irq(irq));
  fsv_seq_model fsv_seq_model_inst (.clk(clk), .resetn(resetn),
    .seq_start(seq_start), .powerdown_req(pd_req), .lag(lag),
    .powerup_done(pu_done), .powerdown_done(pd_done));
  function cond(input integer s);
    case (s)
      0: cond = sys_on;
      1: cond = pd_req;
      2: cond = fld;
      3: cond = seq_start;
      4: cond = locked;
      default: cond = irq;
    endcase
  endfunction
  // Bounded wait; n tells how many edges it took
  task wait_for(input integer s);
    begin
      n = 0;
      while (cond(s) !== 1'b1 && n < 400) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd_chk(input [3:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      `CHK(d, exp)
    end
  endtask
  task boot;
    begin
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wait_for(2);
      `CHK(fld, 1'b1)
    end
  endtask
  task flt(input [1:0] c);
    begin
      @(posedge clk);
      fault_cause <= 4'h1 << c;
      @(posedge clk);
      fault_cause <= 4'h0;
      wait_for(1);
      `CHK(pd_req, 1'b1)
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results;
    end
  end
  initial begin
    // Each nibble: limit, bypass, safety grade, expected lock-down
    {cfg[0], cfg[1], cfg[2], cfg[3]} = 16'h0e3b;
    boot;
    repeat (2) @(posedge clk);
    #1 `CHK(mc_off, 1'b1)
    rd_chk(4'h4, 8'h02);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h2, 8'h05);
    rd_chk(4'h0, 8'h00);
    rd_chk(4'hf, 8'h00);
    $display("test startup done");
    lag <= 8'h28;
    pin <= 1'b1;
    wait_for(3);
    `CHK(n, 21)
    wait_for(0);
    rd_chk(4'h4, 8'h10);
    lag <= 8'h03;
    for (k = 0; k < 4; k++) begin
      flt(k);
      wait_for(0);
    end
    rd_chk(4'h0, 8'h0f);
    rd_chk(4'h1, 8'hf4);
    wr(4'h0, 8'h05);
    rd_chk(4'h0, 8'h0a);
    wr(4'h3, 8'h01);
    rd_chk(4'h3, 8'h01);
    @(posedge clk) off_request <= 1'b1;
    @(posedge clk) off_request <= 1'b0;
    wait_for(1);
    // Low-power-off set: restart skips self-test and the quiet off state
    wait_for(3);
    `CHK({n < 20, mc_off}, 2'b10)
    wait_for(0);
    rd_chk(4'h0, 8'h0a);
    rd_chk(4'h1, 8'hf4);
    repeat (240) @(posedge clk);
    rd_chk(4'h1, 8'hf3);
    wr(4'h1, 8'h00);
    rd_chk(4'h1, 8'hf0);
    repeat (250) @(posedge clk);
    rd_chk(4'h1, 8'hf0);
    $display("test counter done");
    for (k = 0; k < 4; k++) begin
      wr(4'h2, {4'h0, k[1:0], 2'b01});
      @(posedge clk) ov <= 1'b1;
      wait_for(5);
      ov <= 1'b0;
      d = (k == 0) ? `FSV_DBNC0_US * `FSV_CLK_MHZ : (k == 1) ? 5 : 8;
      `CHK(n, d + 1)
      #80 `CHK(sys_on, 1'b1)
    end
    wr(4'h2, 8'h02);
    @(posedge clk) ov <= 1'b1;
    wait_for(5);
    `CHK(n, 400)
    wr(4'h2, 8'h03);
    wait_for(1);
    ov <= 1'b0;
    `CHK(pd_req, 1'b1)
    wait_for(0);
    rd_chk(4'h0, 8'h0a);
    $display("test overvoltage done");
    for (k = 0; k < 4; k++) begin
      {lim, byp, saf} <= {3'h0, cfg[k][3:1]};
      boot;
      wait_for(0);
      if (cfg[k][3]) begin
        flt(2'h1);
        wait_for(0);
        rd_chk(4'h1, 8'h11);
      end
      flt(2'h2);
      wait_for(cfg[k][0] ? 4 : 0);
      `CHK(locked, cfg[k][0])
      repeat (60) @(posedge clk);
      #1 `CHK(sys_on, ~cfg[k][0])
      rd_chk(4'h1, {3'h0, cfg[k][3], 3'h0, cfg[k][3]});
    end
    // New fuse defaults: shutdown on overvoltage, 100 us debounce
    {f_ov_sdwn, f_ov_dbnc} <= 3'b101;
    boot;
    `CHK(locked, 1'b0)
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h2, 8'h07);
    $display("test lockdown done");
    // Overvoltage during power up aborts back to the off state
    lag <= 8'h40;
    wait_for(3);
    ov <= 1'b1;
    wait_for(1);
    `CHK({n, irq}, {32'd6, 1'b0})
    repeat (100) @(posedge clk);
    rd_chk(4'h4, 8'h02);
    `CHK({mc_off, sys_on}, 2'b10)
    rd_chk(4'h0, 8'h00);
    $display("test powerup overvoltage done");
    results;
  end
endmodule // fsv_failsafe_supervisor_tb_top
